// >>> verilog/gpio_led_params.svh
// constants for the pin configuration block: offsets, field positions, reset values, timing
// assumes inclusion by bare name from the package and the modules
// What this block does
// - led_select bit one makes pin an LED output; bits 28..30 for pins 0..2
// - pin_irq_polarity picks which pin level sets the interrupt status bit
// - pin interrupt reaches host only when its pin_irq_enable bit is set
// - pin-function field decodes six codes onto serial memory data and clock pins
// - driver-type bit one gives push-pull, zero gives open-drain
// - direction bit one makes pin an output, zero an input
// - extra-output data bits 3 and 4 drive extra outputs 3 and 4
// - data bits drive output pins; reads return present pin levels
`ifndef GPIO_LED_PARAMS_SVH
`define GPIO_LED_PARAMS_SVH
`define CFG_OFFSET 8'h88
`define IRQ_STATUS_OFFSET 8'h8c
`define IRQ_MASK_OFFSET 8'h90
`define LED_SEL_LSB 28
`define IRQ_POL_LSB 24
`define FUNC_LSB 20
`define DRV_LSB 16
`define DIR_LSB 8
`define XOUT_LSB 3
`define DATA_LSB 0
`define CFG_WRITE_MASK 32'h7777071f
`define CFG_RESET 32'h00000000
`define MIN_ACTIVE_NS 40
`define CLK_PERIOD_NS 100
`define MIN_ACTIVE_CYC (((`MIN_ACTIVE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) < 1 ? 1 : \
  ((`MIN_ACTIVE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))
`endif

// >>> verilog/gpio_led_pkg.sv
// types shared by the pin configuration block
// assumes the params header is on the include path
`include "gpio_led_params.svh"
package gpio_led_pkg;
  typedef enum logic [2:0] {
    fn_serial_mem = 3'h0,
    fn_xout_both = 3'h1,
    fn_res_a = 3'h2,
    fn_xout3_rxdv = 3'h3,
    fn_res_b = 3'h4,
    fn_txen_xout4 = 3'h5,
    fn_txen_rxdv = 3'h6,
    fn_clocks = 3'h7
  } pin_func_e;
  typedef logic [2:0] pin3_t;
endpackage

// >>> verilog/pin_mux_if.sv
// carries the pin-function selection and the extra-output values to the mux
// assumes one producer (top) and one consumer (mux)
`timescale 1ns/1ns
`default_nettype none
interface pin_mux_if;
  logic [2:0] func;
  logic [1:0] xout;
  modport ctrl (output func, output xout);
  modport mux (input func, input xout);
endinterface
`default_nettype wire

// >>> verilog/serial_pin_mux.sv
// function selector for the serial memory data and clock pins
// assumes all sources are synchronous to pclk; outputs are registered
`timescale 1ns/1ns
`default_nettype none
module serial_pin_mux
  import gpio_led_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // selection
  pin_mux_if.mux sel,
  // sources
  input wire logic mem_data_out,
  input wire logic mem_clock_out,
  input wire logic tx_en,
  input wire logic rx_dv,
  input wire logic tx_clk,
  input wire logic rx_clk,
  // pins
  output logic serial_mem_data_pin,
  output logic serial_mem_clock_pin
);
  typedef struct packed {
    logic data;
    logic clock;
  } mux_s;
  mux_s st_r;
  mux_s st_nxt;
  always_comb
  begin
    st_nxt = st_r;
    case (pin_func_e'(sel.func))
      fn_serial_mem:
      begin
        st_nxt.data = mem_data_out;
        st_nxt.clock = mem_clock_out;
      end
      fn_xout_both:
      begin
        st_nxt.data = sel.xout[0];
        st_nxt.clock = sel.xout[1];
      end
      fn_xout3_rxdv:
      begin
        st_nxt.data = sel.xout[0];
        st_nxt.clock = rx_dv;
      end
      fn_txen_xout4:
      begin
        st_nxt.data = tx_en;
        st_nxt.clock = sel.xout[1];
      end
      fn_txen_rxdv:
      begin
        st_nxt.data = tx_en;
        st_nxt.clock = rx_dv;
      end
      fn_clocks:
      begin
        st_nxt.data = tx_clk;
        st_nxt.clock = rx_clk;
      end
      // reserved codes park both pins low rather than guess a function
      default:
      begin
        st_nxt.data = 1'b0;
        st_nxt.clock = 1'b0;
      end
    endcase
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end
  assign serial_mem_data_pin = st_r.data;
  assign serial_mem_clock_pin = st_r.clock;
endmodule
`default_nettype wire

// >>> verilog/gpio_led_pin_config.sv
// pin configuration register, pin drivers, level interrupts and the serial pin selector
// assumes APB master, pins synchronous to pclk, led sources supplied by the MAC
//
// Our own choice: the APB slave port.
`timescale 1ns/1ns
`default_nettype none
`include "gpio_led_params.svh"
module gpio_led_pin_config
  import gpio_led_pkg::*;
#(
  parameter int unsigned NPINS = 3
)
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // general pins and led sources
  input wire logic [NPINS-1:0] pin_in,
  output logic [NPINS-1:0] pin_out,
  output logic [NPINS-1:0] pin_oe_n,
  input wire logic [NPINS-1:0] led_source,
  // serial memory pins and monitor sources
  input wire logic mem_data_out,
  input wire logic mem_clock_out,
  input wire logic tx_en,
  input wire logic rx_dv,
  input wire logic tx_clk,
  input wire logic rx_clk,
  output logic serial_mem_data_pin,
  output logic serial_mem_clock_pin,
  // interrupt
  output logic irq
);
  typedef struct packed {
    logic [31:0] cfg;
    logic [NPINS-1:0] status;
    logic [NPINS-1:0] mask;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic [NPINS-1:0] pout;
    logic [NPINS-1:0] poe_n;
    logic irq;
    logic [NPINS-1:0] hit1;
  } top_s;
  top_s st_r;
  top_s st_nxt;
  logic [NPINS-1:0] active;
  logic access;
  logic wr;
  logic known;
  pin_mux_if mux_bus ();
  assign access = psel && penable && !st_r.ready;
  // writes land on the completion edge, where the master samples pready high
  assign wr = psel && penable && st_r.ready && pwrite;
  assign known = (paddr == `CFG_OFFSET) || (paddr == `IRQ_STATUS_OFFSET) || (paddr == `IRQ_MASK_OFFSET);
  // level active per pin as selected by its polarity bit
  genvar g;
  generate
    for (g = 0; g < NPINS; g++)
    begin : g_pin
      assign active[g] = (pin_in[g] == st_r.cfg[`IRQ_POL_LSB + g]) &&
        !st_r.cfg[`DIR_LSB + g] && !st_r.cfg[`LED_SEL_LSB + g];
    end
  endgenerate
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.ready = access;
    st_nxt.err = access && !known;
    // one sample at 100 ns already exceeds the 40 ns minimum; two consecutive samples filter glitches
    st_nxt.hit1 = active;
    if (wr && paddr == `CFG_OFFSET)
      st_nxt.cfg = pwdata & `CFG_WRITE_MASK;
    if (wr && paddr == `IRQ_MASK_OFFSET)
      st_nxt.mask = pwdata[NPINS-1:0];
    if (wr && paddr == `IRQ_STATUS_OFFSET)
      st_nxt.status = st_r.status & ~pwdata[NPINS-1:0];
    // set wins over a write-one clear in the same cycle
    st_nxt.status = st_nxt.status | (active & st_r.hit1);
    st_nxt.irq = |(st_nxt.status & st_nxt.mask);
    st_nxt.rdata = '0;
    if (access && !pwrite)
    begin
      case (paddr)
        `CFG_OFFSET:
        begin
          st_nxt.rdata = st_r.cfg & `CFG_WRITE_MASK;
          st_nxt.rdata[`DATA_LSB +: NPINS] = pin_in;
        end
        `IRQ_STATUS_OFFSET:
          st_nxt.rdata[NPINS-1:0] = st_r.status;
        `IRQ_MASK_OFFSET:
          st_nxt.rdata[NPINS-1:0] = st_r.mask;
        default:
          st_nxt.rdata = '0;
      endcase
    end
    for (int i = 0; i < NPINS; i++)
    begin
      if (st_r.cfg[`LED_SEL_LSB + i])
      begin
        // led output: push-pull, active level from the MAC
        st_nxt.pout[i] = led_source[i];
        st_nxt.poe_n[i] = 1'b0;
      end
      else if (st_r.cfg[`DIR_LSB + i])
      begin
        st_nxt.pout[i] = st_r.cfg[`DATA_LSB + i];
        // open drain only pulls low and releases for a one
        st_nxt.poe_n[i] = !st_r.cfg[`DRV_LSB + i] && st_r.cfg[`DATA_LSB + i];
      end
      else
      begin
        st_nxt.pout[i] = 1'b0;
        st_nxt.poe_n[i] = 1'b1;
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r <= '0;
      st_r.cfg <= `CFG_RESET;
      st_r.poe_n <= '1;
    end
    else
      st_r <= st_nxt;
  end
  // the function field is applied as soon as written; changing it mid serial cycle corrupts the cycle
  assign mux_bus.func = st_r.cfg[`FUNC_LSB +: 3];
  assign mux_bus.xout = st_r.cfg[`XOUT_LSB +: 2];
  serial_pin_mux u_mux (
    .pclk(pclk),
    .presetn(presetn),
    .sel(mux_bus),
    .mem_data_out(mem_data_out),
    .mem_clock_out(mem_clock_out),
    .tx_en(tx_en),
    .rx_dv(rx_dv),
    .tx_clk(tx_clk),
    .rx_clk(rx_clk),
    .serial_mem_data_pin(serial_mem_data_pin),
    .serial_mem_clock_pin(serial_mem_clock_pin)
  );
  assign prdata = st_r.rdata;
  assign pready = st_r.ready;
  assign pslverr = st_r.err;
  assign pin_out = st_r.pout;
  assign pin_oe_n = st_r.poe_n;
  assign irq = st_r.irq;
endmodule
`default_nettype wire

// >>> dv/gpio_cfg_properties.sv
// checker for the pin configuration block, bound to its top module
// assumes the apb slave and pin ports as the top declares them
`timescale 1ns/1ns
`default_nettype none
module gpio_cfg_properties #(
  parameter int unsigned NPINS = 3
)
(
  // bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // pins
  input wire logic [NPINS-1:0] pin_out,
  input wire logic [NPINS-1:0] pin_oe_n,
  input wire logic serial_mem_data_pin,
  input wire logic serial_mem_clock_pin
);
  // shadow of the last config write; pins are judged only once age saturates
  logic [31:0] cfg_r;
  logic [1:0] age_r;
  wire logic wr_cfg = psel && penable && pready && pwrite && paddr == 8'h88;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      cfg_r <= '0;
      age_r <= 2'h3;
    end
    else
    begin
      cfg_r <= wr_cfg ? pwdata : cfg_r;
      age_r <= wr_cfg ? 2'h0 : (age_r == 2'h3 ? age_r : age_r + 2'h1);
    end
  wire logic set_r = age_r == 2'h3;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  one_wait_a: assert property (psel && penable && !pready |=> pready) else $error("late");
  ready_pulse_a: assert property (pready |=> !pready) else $error("pulse");
  unmapped_err_a: assert property (pready |-> pslverr == !(paddr inside {8'h88, 8'h8c, 8'h90})) else $error("err");
  reserved_zero_a: assert property (pready && !pwrite && paddr == 8'h88 |-> (prdata & 32'h8888f8e0) == '0)
    else $error("rsvd");
  dir_input_a: assert property (set_r && !cfg_r[28] && !cfg_r[8] |-> pin_oe_n[0]) else $error("dir");
  push_pull_a: assert property (set_r && cfg_r[10:8] == 3'h1 && cfg_r[28] == 1'b0 && cfg_r[16]
    |-> !pin_oe_n[0] && pin_out[0] == cfg_r[0]) else $error("pp");
  open_drain_a: assert property (set_r && !cfg_r[28] && cfg_r[8] && !cfg_r[16] |-> pin_oe_n[0] == cfg_r[0])
    else $error("od");
  led_drive_a: assert property (set_r && cfg_r[28] |-> !pin_oe_n[0]) else $error("led");
  xout_pins_a: assert property (set_r && cfg_r[22:20] == 3'h1
    |-> {serial_mem_clock_pin, serial_mem_data_pin} == cfg_r[4:3]) else $error("xout");
  cover property (pready && pslverr);
  cover property (set_r && cfg_r[28]);
  cover property (set_r && cfg_r[22:20] == 3'h7);
endmodule
bind gpio_led_pin_config gpio_cfg_properties #(.NPINS(NPINS)) props (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .pin_out, .pin_oe_n, .serial_mem_data_pin, .serial_mem_clock_pin);
`default_nettype wire

// >>> dv/board_pins.sv
// board side of the general pins: pull-ups and an optional external driver
// assumes oe_n low means the device drives the pin
`timescale 1ns/1ns
`default_nettype none
module board_pins (
  // device side
  input wire logic [2:0] pin_out,
  input wire logic [2:0] pin_oe_n,
  // external driver
  input wire logic [2:0] ext_en,
  input wire logic [2:0] ext_val,
  // sensed level
  output logic [2:0] pin_in
);
  // a released line floats up, so open drain with data one reads high
  always_comb
    for (int i = 0; i < 3; i++)
      pin_in[i] = !pin_oe_n[i] ? pin_out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
endmodule
`default_nettype wire

// >>> dv/testbench.sv
// self-checking bench for the pin configuration block
// assumes the package, the checker with its bind and the board model are compiled first
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin failures++; $display("Error %s exp %h got %h", n, e, g); end end
module testbench;
  import gpio_led_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err, serial_mem_data_pin, serial_mem_clock_pin;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, c;
  logic [2:0] pin_in, pin_out, pin_oe_n, led_source, ext_en, ext_val;
  logic [5:0] src;
  logic [8:0] e;
  int failures = 0;
  int checks_done = 0;
  logic [2:0] codes [6] = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h6, 3'h7};
  gpio_led_pin_config uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .pin_in, .pin_out, .pin_oe_n, .led_source, .mem_data_out(src[5]), .mem_clock_out(src[4]), .tx_en(src[3]),
    .rx_dv(src[2]), .tx_clk(src[1]), .rx_clk(src[0]), .serial_mem_data_pin, .serial_mem_clock_pin, .irq);
  board_pins board (.pin_out, .pin_oe_n, .ext_en, .ext_val, .pin_in);
  // {irq, oe_n, level, data pin, clock pin} with the interrupt masked off
  function automatic logic [8:0] exp_pins(logic [31:0] c, logic [2:0] led, logic [5:0] s);
    logic [2:0] oe, lv;
    logic [1:0] sp;
    for (int i = 0; i < 3; i++)
    begin
      oe[i] = !(c[28+i] || (c[8+i] && (c[16+i] || !c[i])));
      lv[i] = c[28+i] ? led[i] : (c[8+i] ? c[i] : 1'b1);
    end
    case (c[22:20])
      3'h0: sp = s[5:4];
      3'h1: sp = {c[3], c[4]};
      3'h3: sp = {c[3], s[2]};
      3'h5: sp = {s[3], c[4]};
      3'h6: sp = s[3:2];
      default: sp = s[1:0];
    endcase
    return {1'b0, oe, lv, sp};
  endfunction
  task automatic give_verdict();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      failures++;
      give_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  initial
  begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, led_source, ext_en, ext_val, src} = '0;
    void'($urandom(32'hdb5aa04b));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, 8'h88, 0);
    `CHK("cfg reset", 32'h7, rd)
    `CHK("oe reset", 3'h7, pin_oe_n)
    apb(1, 8'h94, 32'hffffffff);
    apb(0, 8'h94, 0);
    `CHK("unmapped", 33'h100000000, {err, rd})
    $display("test reset done");
    for (int i = 0; i < 24; i++)
    begin
      c = $urandom();
      c[22:20] = codes[i % 6];
      led_source <= 3'($urandom());
      src <= 6'($urandom());
      apb(1, 8'h88, c);
      repeat (3) @(posedge pclk);
      e = exp_pins(c, led_source, src);
      apb(0, 8'h88, 0);
      `CHK("cfg read", (c & 32'h77770718) | 32'(e[4:2]), rd)
      `CHK("pins", e, {irq, pin_oe_n, pin_in, serial_mem_data_pin, serial_mem_clock_pin})
    end
    $display("test config done");
    apb(1, 8'h88, 32'h01000000);
    ext_val <= 3'h1;
    ext_en <= 3'h3;
    apb(1, 8'h8c, 32'h7);
    repeat (5) @(posedge pclk);
    apb(0, 8'h8c, 0);
    `CHK("status", 32'h3, rd)
    `CHK("irq masked", 1'b0, irq)
    apb(1, 8'h90, 32'h2);
    repeat (2) @(posedge pclk);
    `CHK("irq", 1'b1, irq)
    ext_val <= 3'h2;
    repeat (3) @(posedge pclk);
    apb(1, 8'h8c, 32'h1);
    apb(0, 8'h8c, 0);
    `CHK("part clear", 33'h100000002, {irq, rd})
    apb(1, 8'h8c, 32'h2);
    repeat (2) @(posedge pclk);
    `CHK("irq clear", 1'b0, irq)
    $display("test irq done");
    give_verdict();
  end
endmodule
`default_nettype wire
